// >>> adc_out_dev.sv
// converter back end: filter, clipping, serial output, control registers
//
// The serial control port interface to the registers was chosen for this implementation.
`default_nettype none
module adc_out_dev (
  input  wire logic                            clk,
  input  wire logic                            srst,
  adc_link_if.dev                              lk,
  input  wire logic signed [adc_link_pkg::IN_W-1:0] pcm_in [2],
  input  wire logic                            pcm_valid,
  input  wire logic                            ext_conv_in_a,
  input  wire logic                            ext_conv_in_b,
  input  wire logic                            ext_ref_clk,
  input  wire logic                            pll_clk,
  output logic                                 recovered_clk_out,
  output logic [adc_link_pkg::GPO_N-1:0]       general_out_pin,
  output logic [7:0]                           osr_ratio
);
  import adc_link_pkg::*;
  localparam int EST_W = IN_W + HPF_SHIFT;

  // pin synchronisers
  logic [8:0] pins_s;
  sync2 #(.W(9)) u_sync (
    .clk  (clk),
    .srst (srst),
    .d    ({lk.frame_clk, lk.bit_clk, lk.spi_sck, lk.spi_csn, lk.spi_mosi,
            ext_conv_in_a, ext_conv_in_b, ext_ref_clk, pll_clk}),
    .q    (pins_s)
  );
  logic s_frame, s_bclk, s_sck, s_csn, s_mosi, s_ea, s_eb, s_ref, s_pll;
  assign {s_frame, s_bclk, s_sck, s_csn, s_mosi, s_ea, s_eb, s_ref, s_pll} = pins_s;

  // registers and control-port state
  logic [7:0] speed_r, speed_nxt, misc_r, misc_nxt, clock_r, clock_nxt;
  logic [7:0] gpo_r [GPO_N];
  logic [7:0] gpo_nxt [GPO_N];
  logic       ovf_r, ovf_nxt, ovf_evt;
  logic       sck_q_r, sck_q_nxt, miso_r, miso_nxt;
  logic [4:0] scnt_r, scnt_nxt;
  logic [14:0] ssh_r, ssh_nxt;
  logic [7:0] msh_r, msh_nxt;
  logic [ADDR_W-1:0] raddr;

  function automatic logic [7:0] rd_reg(input logic [ADDR_W-1:0] a);
    logic [7:0] v;
    v = 8'h00;
    if (a == REG_SPEED) v = speed_r;
    else if (a == REG_MISC) v = misc_r;
    else if (a == REG_CLOCK) v = clock_r;
    else if (a == REG_EVENTS) v = {7'h00, ovf_r};
    else if (a >= REG_GPO_BASE && a <= REG_GPO_LAST) v = gpo_r[3'(a - REG_GPO_BASE)];
    return v;
  endfunction : rd_reg

  // serial control port: byte 0 = {read, addr}, byte 1 = data
  always_comb begin
    speed_nxt = speed_r;
    misc_nxt  = misc_r;
    clock_nxt = clock_r;
    gpo_nxt   = gpo_r;
    ovf_nxt   = ovf_r;
    sck_q_nxt = s_sck;
    scnt_nxt  = scnt_r;
    ssh_nxt   = ssh_r;
    msh_nxt   = msh_r;
    miso_nxt  = miso_r;
    raddr     = {ssh_r[5:0], s_mosi};
    if (s_csn) begin
      scnt_nxt = 5'h00;
    end else if (s_sck && !sck_q_r) begin
      ssh_nxt  = {ssh_r[13:0], s_mosi};
      scnt_nxt = scnt_r + 5'h01;
      if (scnt_r == 5'(SPI_BITS/2 - 1) && ssh_r[6]) begin
        msh_nxt = rd_reg(raddr);
        if (raddr == REG_EVENTS) ovf_nxt = 1'b0;
      end
      if (scnt_r == 5'(SPI_BITS - 1) && !ssh_r[14]) begin
        if (ssh_r[13:7] == REG_SPEED) speed_nxt = {ssh_r[6:0], s_mosi};
        if (ssh_r[13:7] == REG_MISC) misc_nxt = {ssh_r[6:0], s_mosi};
        if (ssh_r[13:7] == REG_CLOCK) clock_nxt = {ssh_r[6:0], s_mosi};
        for (int i = 0; i < GPO_N; i++) begin
          if (ssh_r[13:7] == REG_GPO_BASE + ADDR_W'(i)) gpo_nxt[i] = {ssh_r[6:0], s_mosi};
        end
      end
    end else if (!s_sck && sck_q_r && scnt_r >= 5'(SPI_BITS/2)) begin
      miso_nxt = msh_r[7];
      msh_nxt  = {msh_r[6:0], 1'b0};
    end
    if (ovf_evt) ovf_nxt = 1'b1;
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      speed_r <= RST_SPEED;
      misc_r  <= RST_MISC;
      clock_r <= RST_CLOCK;
      gpo_r   <= '{default: RST_GPO};
      ovf_r   <= 1'b0;
      sck_q_r <= 1'b0;
      scnt_r  <= 5'h00;
      ssh_r   <= '0;
      msh_r   <= 8'h00;
      miso_r  <= 1'b0;
    end else begin
      speed_r <= speed_nxt;
      misc_r  <= misc_nxt;
      clock_r <= clock_nxt;
      gpo_r   <= gpo_nxt;
      ovf_r   <= ovf_nxt;
      sck_q_r <= sck_q_nxt;
      scnt_r  <= scnt_nxt;
      ssh_r   <= ssh_nxt;
      msh_r   <= msh_nxt;
      miso_r  <= miso_nxt;
    end
  end

  // offset filter and clipping per channel
  logic signed [EST_W-1:0] est_r [2];
  logic signed [EST_W-1:0] est_nxt [2];
  logic [SAMPLE_W-1:0] samp_r [2];
  logic [SAMPLE_W-1:0] samp_nxt [2];
  logic hpf_en, hold;
  assign hpf_en = misc_r[HPF_EN_BIT];
  assign hold   = misc_r[HOLD_BIT];

  always_comb begin
    logic signed [EST_W:0] diff;
    logic signed [IN_W:0]  y;
    diff     = '0;
    y        = '0;
    est_nxt  = est_r;
    samp_nxt = samp_r;
    ovf_evt  = 1'b0;
    for (int c = 0; c < 2; c++) begin
      diff = {pcm_in[c][IN_W-1], pcm_in[c], {HPF_SHIFT{1'b0}}}
           - {est_r[c][EST_W-1], est_r[c]};
      y = {pcm_in[c][IN_W-1], pcm_in[c]};
      if (hpf_en || hold) begin
        y = y - {est_r[c][EST_W-1], est_r[c][EST_W-1:HPF_SHIFT]};
      end
      if (pcm_valid) begin
        if (hpf_en && !hold) begin
          est_nxt[c] = est_r[c] + EST_W'($signed(diff[EST_W:HPF_SHIFT]));
        end
        if (&y[IN_W:SAMPLE_W-1] || ~|y[IN_W:SAMPLE_W-1]) begin
          samp_nxt[c] = y[SAMPLE_W-1:0];
        end else begin
          samp_nxt[c] = y[IN_W] ? CODE_MIN : CODE_MAX;
          ovf_evt     = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      est_r  <= '{default: '0};
      samp_r <= '{default: '0};
    end else begin
      est_r  <= est_nxt;
      samp_r <= samp_nxt;
    end
  end

  // serial port: clock generation as master, one-line output framing
  logic [$clog2(BCLK_HALF)-1:0] div_r, div_nxt;
  logic [6:0] gcnt_r, gcnt_nxt, tcnt_r, tcnt_nxt, idx;
  logic gbclk_r, gbclk_nxt, gframe_r, gframe_nxt, master_r, master_nxt;
  logic bclk_q_r, bclk_q_nxt, fq_r, fq_nxt, out_r, out_nxt;
  logic [SAMPLE_W-1:0] own_r, own_nxt, ea_r, ea_nxt, eb_r, eb_nxt;
  logic [HALF_BITS-1:0] word;
  logic one_line;
  assign one_line = speed_r[ONE_LINE_BIT];

  always_comb begin
    master_nxt = clock_r[MASTER_BIT];
    div_nxt    = div_r + 1'b1;
    gbclk_nxt  = gbclk_r;
    gframe_nxt = gframe_r;
    gcnt_nxt   = gcnt_r;
    if (div_r == $bits(div_r)'(BCLK_HALF - 1)) begin
      div_nxt   = '0;
      gbclk_nxt = !gbclk_r;
      if (gbclk_r) begin
        gcnt_nxt = gcnt_r + 7'h01;
        if (gcnt_r == 7'(HALF_BITS - 1)) begin
          gcnt_nxt   = 7'h00;
          gframe_nxt = !gframe_r;
        end
      end
    end
    bclk_q_nxt = s_bclk;
    fq_nxt   = fq_r;
    tcnt_nxt = tcnt_r;
    own_nxt  = own_r;
    ea_nxt   = ea_r;
    eb_nxt   = eb_r;
    out_nxt  = out_r;
    idx      = tcnt_r;
    if (!s_bclk && bclk_q_r) begin
      if (s_frame != fq_r) begin
        fq_nxt  = s_frame;
        idx     = 7'h00;
        own_nxt = s_frame ? samp_r[1] : samp_r[0];
      end
      word     = {own_nxt, ea_r, eb_r};
      out_nxt  = 1'b0;
      if (idx < 7'(SAMPLE_W) || (one_line && idx < 7'(HALF_BITS))) begin
        out_nxt = word[7'(HALF_BITS - 1) - idx];
      end
      tcnt_nxt = (idx < 7'(HALF_BITS)) ? idx + 7'h01 : idx;
    end else begin
      word = {own_r, ea_r, eb_r};
      if (s_bclk && !bclk_q_r && tcnt_r != 7'h00 && tcnt_r <= 7'(SAMPLE_W)) begin
        ea_nxt = {ea_r[SAMPLE_W-2:0], s_ea};
        eb_nxt = {eb_r[SAMPLE_W-2:0], s_eb};
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      div_r    <= '0;
      gcnt_r   <= 7'h00;
      gbclk_r  <= 1'b0;
      gframe_r <= 1'b0;
      master_r <= 1'b0;
      bclk_q_r <= 1'b0;
      fq_r     <= 1'b0;
      tcnt_r   <= 7'h00;
      own_r    <= '0;
      ea_r     <= '0;
      eb_r     <= '0;
      out_r    <= 1'b0;
    end else begin
      div_r    <= div_nxt;
      gcnt_r   <= gcnt_nxt;
      gbclk_r  <= gbclk_nxt;
      gframe_r <= gframe_nxt;
      master_r <= master_nxt;
      bclk_q_r <= bclk_q_nxt;
      fq_r     <= fq_nxt;
      tcnt_r   <= tcnt_nxt;
      own_r    <= own_nxt;
      ea_r     <= ea_nxt;
      eb_r     <= eb_nxt;
      out_r    <= out_nxt;
    end
  end
  assign lk.bit_dev_o    = gbclk_r;
  assign lk.frame_dev_o  = gframe_r;
  assign lk.bit_dev_oe   = master_r;
  assign lk.frame_dev_oe = master_r;
  assign lk.serial_out   = out_r;
  assign lk.spi_miso     = miso_r;

  // clock select, speed ratio and general outputs
  logic rclk_nxt;
  logic [7:0] osr_nxt;
  logic [GPO_N-1:0] gpo_pin_nxt;
  always_comb begin
    rclk_nxt = clock_r[CLK_SRC_BIT] ? s_pll : s_ref;
    case (speed_r[SPD_LSB +: 2])
      DOUBLE_RATE: osr_nxt = OSR_DOUBLE;
      QUAD_RATE:   osr_nxt = OSR_QUAD;
      default:     osr_nxt = OSR_SINGLE;
    endcase
  end
  for (genvar g = 0; g < GPO_N; g++) begin : g_gpo
    assign gpo_pin_nxt[g] = gpo_r[g][GPO_OVF_BIT] ? ovf_r : gpo_r[g][GPO_LVL_BIT];
  end
  always_ff @(posedge clk) begin
    if (srst) begin
      recovered_clk_out <= 1'b0;
      osr_ratio         <= OSR_SINGLE;
      general_out_pin   <= '0;
    end else begin
      recovered_clk_out <= rclk_nxt;
      osr_ratio         <= osr_nxt;
      general_out_pin   <= gpo_pin_nxt;
    end
  end
endmodule : adc_out_dev
`default_nettype wire

// >>> adc_link_pkg.sv
// shared constants for the converter output path and its host controller
`default_nettype none
package adc_link_pkg;
  // Functional notes
  // - three speed modes: 128x, 64x, 32x oversampling
  // - speed_select field in register 03h chooses mode
  // - output samples are two's complement words
  // - clip to maximum or most negative code
  // - clipping sets overflow flag at 20h
  // - general outputs can show converter overflow
  // - enabled filter tracks and subtracts DC offset
  // - filter has its own enable bit
  // - offset_hold freezes and keeps subtracting the offset
  // - offset_hold bit lives in register 05h
  // - software settles filter, then disables and freezes
  // - one-line mode merges two external stereo inputs
  // - serial output carries internal and external samples
  // - frame clock marks left/right, master drives it
  // - bit clock times serial bits, master drives it
  // - recovered clock output from reference or PLL
  // - system clock selectable between PLL and reference; here clk is a fixed input and only the recovered clock output has that select
  // - configuration written through serial control port
  localparam int ADDR_W   = 7;
  localparam int SAMPLE_W = 24;
  localparam int IN_W     = 26;
  localparam int SLOTS    = 3;
  localparam int HALF_BITS = SAMPLE_W * SLOTS;
  localparam int GPO_N    = 7;
  localparam int HPF_SHIFT = 10;
  localparam int SPI_BITS = 16;
  localparam int SPI_HALF = 8;
  localparam int BCLK_HALF = 12;
  // device register offsets
  localparam logic [ADDR_W-1:0] REG_SPEED    = 7'h03;
  localparam logic [ADDR_W-1:0] REG_MISC     = 7'h05;
  localparam logic [ADDR_W-1:0] REG_CLOCK    = 7'h06;
  localparam logic [ADDR_W-1:0] REG_EVENTS   = 7'h20;
  localparam logic [ADDR_W-1:0] REG_GPO_BASE = 7'h29;
  localparam logic [ADDR_W-1:0] REG_GPO_LAST = 7'h2F;
  // device field positions
  localparam int SPD_LSB      = 4;
  localparam int ONE_LINE_BIT = 0;
  localparam int HOLD_BIT     = 0;
  localparam int HPF_EN_BIT   = 1;
  localparam int CLK_SRC_BIT  = 0;
  localparam int MASTER_BIT   = 1;
  localparam int OVF_BIT      = 0;
  localparam int GPO_LVL_BIT  = 0;
  localparam int GPO_OVF_BIT  = 1;
  // reset values
  localparam logic [7:0] RST_SPEED = 8'h00;
  localparam logic [7:0] RST_MISC  = 8'h02;
  localparam logic [7:0] RST_CLOCK = 8'h00;
  localparam logic [7:0] RST_GPO   = 8'h00;
  // speed modes and oversampling ratios
  localparam logic [1:0] SINGLE_RATE = 2'h0;
  localparam logic [1:0] DOUBLE_RATE = 2'h1;
  localparam logic [1:0] QUAD_RATE   = 2'h2;
  localparam logic [7:0] OSR_SINGLE  = 8'h80;
  localparam logic [7:0] OSR_DOUBLE  = 8'h40;
  localparam logic [7:0] OSR_QUAD    = 8'h20;
  localparam logic [SAMPLE_W-1:0] CODE_MAX = 24'h7FFFFF;
  localparam logic [SAMPLE_W-1:0] CODE_MIN = 24'h800000;
  // host APB map
  localparam logic [11:0] H_CTRL    = 12'h000;
  localparam logic [11:0] H_CMD     = 12'h004;
  localparam logic [11:0] H_STAT    = 12'h008;
  localparam logic [11:0] H_IRQ_ST  = 12'h00C;
  localparam logic [11:0] H_IRQ_CLR = 12'h010;
  localparam logic [11:0] H_IRQ_EN  = 12'h014;
  localparam logic [11:0] H_RX_BASE = 12'h020;
  localparam int IRQ_SPI  = 0;
  localparam int IRQ_RX   = 1;
  localparam int H_MASTER_BIT = 0;
  localparam int CMD_RW_BIT   = 15;
  localparam int STAT_BUSY_BIT = 8;
endpackage : adc_link_pkg
`default_nettype wire

// >>> adc_link_if.sv
// serial audio and control link between converter and host
`default_nettype none
interface adc_link_if;
  logic frame_dev_o, frame_dev_oe, frame_host_o, frame_host_oe;
  logic bit_dev_o, bit_dev_oe, bit_host_o, bit_host_oe;
  logic frame_clk, bit_clk, serial_out;
  logic spi_sck, spi_csn, spi_mosi, spi_miso;
  // resolve the two-way clock pins from the enables
  assign frame_clk = frame_dev_oe ? frame_dev_o : (frame_host_oe & frame_host_o);
  assign bit_clk   = bit_dev_oe ? bit_dev_o : (bit_host_oe & bit_host_o);
  modport dev (input frame_clk, bit_clk, spi_sck, spi_csn, spi_mosi,
               output frame_dev_o, frame_dev_oe, bit_dev_o, bit_dev_oe,
               serial_out, spi_miso);
  modport host (input frame_clk, bit_clk, serial_out, spi_miso,
                output frame_host_o, frame_host_oe, bit_host_o, bit_host_oe,
                spi_sck, spi_csn, spi_mosi);
endinterface : adc_link_if
`default_nettype wire

// >>> sync2.sv
// two-flop synchroniser for pin levels
`default_nettype none
module sync2 #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         srst,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_r;
  // first stage feeds only the second
  always_ff @(posedge clk) begin
    if (srst) begin
      meta_r <= '0;
      q      <= '0;
    end else begin
      meta_r <= d;
      q      <= meta_r;
    end
  end
endmodule : sync2
`default_nettype wire

// >>> adc_out_host.sv
// host controller: APB registers, control-port master, serial receiver
`default_nettype none
module adc_out_host (
  input  wire logic        clk,
  input  wire logic        srst,
  input  wire logic [11:0] paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             irq,
  adc_link_if.host         lk
);
  import adc_link_pkg::*;
  typedef enum {S_IDLE, S_LOW, S_HIGH} spi_st_t;

  // pins_s: [3] miso, [2] frame, [1] bit clock, [0] serial data
  logic [3:0] pins_s;
  sync2 #(.W(4)) u_sync (
    .clk  (clk),
    .srst (srst),
    .d    ({lk.spi_miso, lk.frame_clk, lk.bit_clk, lk.serial_out}),
    .q    (pins_s)
  );

  spi_st_t st_r, st_nxt;
  logic [7:0]  ctrl_r, ctrl_nxt, rd_r, rd_nxt;
  logic [1:0]  ist_r, ist_nxt, ien_r, ien_nxt, iset;
  logic [15:0] osh_r, osh_nxt;
  logic [4:0]  bcnt_r, bcnt_nxt;
  logic [3:0]  hdiv_r, hdiv_nxt;
  logic        sck_r, sck_nxt, csn_r, csn_nxt, pready_nxt, slverr_nxt, irq_nxt;
  logic [31:0] prdata_nxt;
  logic [SAMPLE_W-1:0] rx_r [2*SLOTS];
  logic        wr, busy, rx_done;
  assign wr   = psel && penable && pready;
  assign busy = (st_r != S_IDLE);

  // APB slave, control-port engine and event flags
  always_comb begin
    ctrl_nxt = ctrl_r;
    ien_nxt  = ien_r;
    ist_nxt  = ist_r;
    st_nxt   = st_r;
    osh_nxt  = osh_r;
    rd_nxt   = rd_r;
    bcnt_nxt = bcnt_r;
    hdiv_nxt = hdiv_r + 4'h1;
    sck_nxt  = sck_r;
    csn_nxt  = csn_r;
    iset     = {rx_done, 1'b0};
    pready_nxt = psel && !penable;
    slverr_nxt = 1'b0;
    prdata_nxt = 32'h0000_0000;
    if (psel && !penable) begin
      if (paddr == H_CTRL) prdata_nxt = {24'h000000, ctrl_r};
      else if (paddr == H_STAT) prdata_nxt = {23'h000000, busy, rd_r};
      else if (paddr == H_IRQ_ST) prdata_nxt = {30'h00000000, ist_r};
      else if (paddr == H_IRQ_EN) prdata_nxt = {30'h00000000, ien_r};
      else if (paddr >= H_RX_BASE && paddr < H_RX_BASE + 12'(4 * 2 * SLOTS)
               && paddr[1:0] == 2'h0) begin
        prdata_nxt = {8'h00, rx_r[3'((paddr - H_RX_BASE) >> 2)]};
      end else if (paddr != H_CMD && paddr != H_IRQ_CLR) slverr_nxt = 1'b1;
    end
    if (wr && paddr == H_CTRL) ctrl_nxt = pwdata[7:0];
    if (wr && paddr == H_IRQ_EN) ien_nxt = pwdata[1:0];
    if (wr && paddr == H_IRQ_CLR) ist_nxt = ist_r & ~pwdata[1:0];
    unique case (st_r)
      S_IDLE: begin
        hdiv_nxt = 4'h0;
        if (wr && paddr == H_CMD) begin
          osh_nxt  = pwdata[15:0];
          bcnt_nxt = 5'h00;
          csn_nxt  = 1'b0;
          st_nxt   = S_LOW;
        end
      end
      S_LOW: begin
        if (hdiv_r == 4'(SPI_HALF - 1)) begin
          hdiv_nxt = 4'h0;
          sck_nxt  = 1'b1;
          st_nxt   = S_HIGH;
        end
      end
      S_HIGH: begin
        if (hdiv_r == 4'(SPI_HALF - 1)) begin
          hdiv_nxt = 4'h0;
          sck_nxt  = 1'b0;
          bcnt_nxt = bcnt_r + 5'h01;
          osh_nxt  = {osh_r[14:0], 1'b0};
          if (bcnt_r >= 5'(SPI_BITS/2)) rd_nxt = {rd_r[6:0], pins_s[3]};
          st_nxt   = S_LOW;
          if (bcnt_r == 5'(SPI_BITS - 1)) begin
            csn_nxt = 1'b1;
            st_nxt  = S_IDLE;
            iset[IRQ_SPI] = 1'b1;
          end
        end
      end
    endcase
    ist_nxt = ist_nxt | iset;
    irq_nxt = |(ist_nxt & ien_nxt);
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      ctrl_r  <= 8'h00;
      ien_r   <= 2'h0;
      ist_r   <= 2'h0;
      st_r    <= S_IDLE;
      osh_r   <= 16'h0000;
      rd_r    <= 8'h00;
      bcnt_r  <= 5'h00;
      hdiv_r  <= 4'h0;
      sck_r   <= 1'b0;
      csn_r   <= 1'b1;
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
      irq     <= 1'b0;
    end else begin
      ctrl_r  <= ctrl_nxt;
      ien_r   <= ien_nxt;
      ist_r   <= ist_nxt;
      st_r    <= st_nxt;
      osh_r   <= osh_nxt;
      rd_r    <= rd_nxt;
      bcnt_r  <= bcnt_nxt;
      hdiv_r  <= hdiv_nxt;
      sck_r   <= sck_nxt;
      csn_r   <= csn_nxt;
      pready  <= pready_nxt;
      pslverr <= slverr_nxt;
      prdata  <= prdata_nxt;
      irq     <= irq_nxt;
    end
  end
  assign lk.spi_sck  = sck_r;
  assign lk.spi_csn  = csn_r;
  assign lk.spi_mosi = osh_r[15];

  // clock generation as master and slot receiver
  logic [$clog2(BCLK_HALF)-1:0] div_r, div_nxt;
  logic [6:0] gcnt_r, gcnt_nxt, rcnt_r, rcnt_nxt;
  logic gb_r, gb_nxt, gf_r, gf_nxt, m_r, bq_r, fq_r, fq_nxt;
  logic [SAMPLE_W-1:0] rsh_r, rsh_nxt;
  logic [SAMPLE_W-1:0] rx_nxt [2*SLOTS];
  always_comb begin
    div_nxt  = div_r + 1'b1;
    gb_nxt   = gb_r;
    gf_nxt   = gf_r;
    gcnt_nxt = gcnt_r;
    if (div_r == $bits(div_r)'(BCLK_HALF - 1)) begin
      div_nxt = '0;
      gb_nxt  = !gb_r;
      if (gb_r) begin
        gcnt_nxt = gcnt_r + 7'h01;
        if (gcnt_r == 7'(HALF_BITS - 1)) begin
          gcnt_nxt = 7'h00;
          gf_nxt   = !gf_r;
        end
      end
    end
    fq_nxt   = fq_r;
    rcnt_nxt = rcnt_r;
    rsh_nxt  = rsh_r;
    rx_nxt   = rx_r;
    rx_done  = 1'b0;
    if (pins_s[1] && !bq_r) begin
      rcnt_nxt = rcnt_r + 7'h01;
      if (pins_s[2] != fq_r) begin
        fq_nxt   = pins_s[2];
        rcnt_nxt = 7'h01;
      end
      rsh_nxt = {rsh_r[SAMPLE_W-2:0], pins_s[0]};
      for (int s = 1; s <= SLOTS; s++) begin
        if (rcnt_nxt == 7'(s * SAMPLE_W)) begin
          rx_nxt[(fq_nxt ? SLOTS : 0) + s - 1] = rsh_nxt;
          rx_done = fq_nxt && (s == SLOTS);
        end
      end
    end
  end
  always_ff @(posedge clk) begin
    if (srst) begin
      div_r  <= '0;
      gcnt_r <= 7'h00;
      gb_r   <= 1'b0;
      gf_r   <= 1'b0;
      m_r    <= 1'b0;
      bq_r   <= 1'b0;
      fq_r   <= 1'b0;
      rcnt_r <= 7'h00;
      rsh_r  <= '0;
      rx_r   <= '{default: '0};
    end else begin
      div_r  <= div_nxt;
      gcnt_r <= gcnt_nxt;
      gb_r   <= gb_nxt;
      gf_r   <= gf_nxt;
      m_r    <= ctrl_r[H_MASTER_BIT];
      bq_r   <= pins_s[1];
      fq_r   <= fq_nxt;
      rcnt_r <= rcnt_nxt;
      rsh_r  <= rsh_nxt;
      rx_r   <= rx_nxt;
    end
  end
  assign lk.bit_host_o    = gb_r;
  assign lk.frame_host_o  = gf_r;
  assign lk.bit_host_oe   = m_r;
  assign lk.frame_host_oe = m_r;
endmodule : adc_out_host
`default_nettype wire

// >>> adc_link_checker.sv
// concurrent checks on the converter link wires
`default_nettype none
module adc_link_checker (
  input wire logic clk,
  input wire logic srst,
  input wire logic frame_dev_oe,
  input wire logic frame_host_oe,
  input wire logic bit_dev_oe,
  input wire logic bit_host_oe,
  input wire logic frame_clk,
  input wire logic bit_clk,
  input wire logic serial_out,
  input wire logic spi_sck,
  input wire logic spi_csn,
  input wire logic spi_mosi
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  // twelve-cycle high phase of the bit clock, then its fall
  sequence s_bit_hi; bit_clk [*8] ##4 bit_clk ##1 $fell(bit_clk); endsequence
  // eight-cycle high phase of the control clock, then low
  sequence s_sck_hi; spi_sck [*8] ##1 !spi_sck; endsequence
  AST_FRAME_ONE: assert property (!(frame_dev_oe && frame_host_oe)) else $error("two frame drivers");
  AST_BIT_ONE: assert property (!(bit_dev_oe && bit_host_oe)) else $error("two bit drivers");
  // a driver switched on mid-phase shows a short first high phase
  AST_BIT_HALF: assert property ($rose(bit_clk) && bit_dev_oe && $stable(bit_dev_oe)
    |-> s_bit_hi) else $error("bit half");
  AST_FRAME_EDGE: assert property ($changed(frame_clk) && $stable(frame_dev_oe) && frame_dev_oe
    |-> !bit_clk) else $error("frame edge while bit high");
  AST_OUT_LOW: assert property ($changed(serial_out) |-> !bit_clk) else $error("data moved");
  AST_CSN_GAP: assert property ($rose(spi_csn) |-> spi_csn [*3]) else $error("select gap");
  AST_SCK_IDLE: assert property (spi_csn |-> !spi_sck) else $error("clock while idle");
  AST_SCK_HALF: assert property ($rose(spi_sck) |-> s_sck_hi) else $error("sck high phase");
  AST_MOSI_HOLD: assert property (spi_sck |-> $stable(spi_mosi)) else $error("mosi moved");
endmodule : adc_link_checker
`default_nettype wire

// >>> tb_adc_output_path_hpf_overflow.sv
// self-checking bench joining converter back end and host controller
`default_nettype none
module tb_adc_output_path_hpf_overflow;
  timeunit 1ns;
  timeprecision 100ps;
  import adc_link_pkg::*;
  logic clk = 0, srst = 1, psel = 0, penable = 0, pwrite = 0, pcm_valid = 0, ext_ref_clk = 0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata;
  logic pready, pslverr, irq, recovered_clk_out, last_err;
  logic [GPO_N-1:0] general_out_pin;
  logic [7:0] osr_ratio;
  logic signed [IN_W-1:0] pcm_in [2] = '{default: '0};
  int n_mismatch = 0, checked = 0;
  adc_link_if lk ();
  adc_out_dev i_adc_out_dev (.clk, .srst, .lk(lk.dev), .pcm_in, .pcm_valid,
    .ext_conv_in_a(1'b1), .ext_conv_in_b(1'b0), .ext_ref_clk, .pll_clk(1'b1),
    .recovered_clk_out, .general_out_pin, .osr_ratio);
  adc_out_host i_adc_out_host (.clk, .srst, .paddr, .psel, .penable, .pwrite, .pwdata,
    .prdata, .pready, .pslverr, .irq, .lk(lk.host));
  adc_link_checker i_adc_link_checker (.clk, .srst, .frame_dev_oe(lk.frame_dev_oe),
    .frame_host_oe(lk.frame_host_oe), .bit_dev_oe(lk.bit_dev_oe), .bit_host_oe(lk.bit_host_oe),
    .frame_clk(lk.frame_clk), .bit_clk(lk.bit_clk), .serial_out(lk.serial_out),
    .spi_sck(lk.spi_sck), .spi_csn(lk.spi_csn), .spi_mosi(lk.spi_mosi));
  // clocks
  initial begin
    forever #2.5 clk = ~clk;
  end
  always @(posedge clk) ext_ref_clk <= ~ext_ref_clk;
  // verdict and end of run
  task automatic finish_test();
    $display("mismatches %0d checks %0d", n_mismatch, checked);
    if (n_mismatch == 0 && checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : finish_test
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: got %h want %h", $time, seen, exp);
    end
  endtask : chk
  task automatic tmo();
    n_mismatch++;
    $display("mismatch at %0t: wait ran out", $time);
    finish_test();
  endtask : tmo
  // one APB transfer, held until pready
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) tmo();
    q = prdata;
    last_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  // device register access over the control link
  task automatic dev(input logic rd, input logic [6:0] a, input logic [7:0] d,
                     output logic [7:0] q);
    logic [31:0] r;
    int n;
    n = 0;
    apb(1'b1, H_CMD, {16'h0, rd, a, d}, r);
    do begin
      apb(1'b0, H_STAT, 32'h0, r);
      n++;
    end while (r[STAT_BUSY_BIT] !== 1'b0 && n < 200);
    if (r[STAT_BUSY_BIT] !== 1'b0) tmo();
    q = r[7:0];
  endtask : dev
  task automatic wait_rx();
    logic [31:0] r;
    int n;
    n = 0;
    repeat (2) @(posedge clk);
    while (irq !== 1'b1 && n < 8000) begin
      @(posedge clk);
      n++;
    end
    if (irq !== 1'b1) tmo();
    apb(1'b1, H_IRQ_CLR, 32'h2, r);
  endtask : wait_rx
  task automatic pulse(input logic signed [IN_W-1:0] l, input logic signed [IN_W-1:0] rt,
                       input int k);
    repeat (k) begin
      @(posedge clk);
      pcm_in[0] <= l;
      pcm_in[1] <= rt;
      pcm_valid <= 1'b1;
      @(posedge clk);
      pcm_valid <= 1'b0;
    end
  endtask : pulse
  // reset values, unmapped host address, speed modes
  task automatic t_regs();
    logic [7:0] q;
    logic [31:0] r;
    chk(osr_ratio, 8'h80);
    dev(1'b1, REG_SPEED, 8'h00, q);
    chk(q, 8'h00);
    dev(1'b1, REG_MISC, 8'h00, q);
    chk(q, 8'h02);
    // reference clock toggles each cycle, output lags it by three
    @(negedge clk);
    chk(recovered_clk_out, !ext_ref_clk);
    apb(1'b0, 12'hFF0, 32'h0, r);
    chk(last_err, 1'b1);
    for (int i = 0; i < 4; i++) begin
      dev(1'b0, REG_SPEED, 8'(i << SPD_LSB), q);
      chk(osr_ratio, i == 1 ? 8'h40 : i == 2 ? 8'h20 : 8'h80);
    end
  endtask : t_regs
  // clipped samples, overflow flag, pins, merged external streams
  task automatic t_clip();
    logic [7:0] q;
    logic [31:0] r;
    dev(1'b0, REG_SPEED, 8'h01, q);
    dev(1'b0, REG_MISC, 8'h00, q);
    dev(1'b0, REG_GPO_BASE, 8'h02, q);
    dev(1'b0, REG_GPO_BASE + 7'h1, 8'h01, q);
    dev(1'b0, REG_CLOCK, 8'h03, q);
    apb(1'b1, H_IRQ_EN, 32'h2, r);
    pulse(26'sh1000000, 26'sh3000000, 1);
    wait_rx();
    wait_rx();
    apb(1'b0, H_RX_BASE, 32'h0, r);
    chk(r, 32'h7FFFFF);
    apb(1'b0, H_RX_BASE + 12'hC, 32'h0, r);
    chk(r, 32'h800000);
    for (int i = 1; i < 6; i++) begin
      if (i != 3) begin
        apb(1'b0, H_RX_BASE + 12'(i * 4), 32'h0, r);
        chk(r, (i % 3 == 1) ? 32'hFFFFFF : 32'h0);
      end
    end
    chk(general_out_pin, 7'h03);
    dev(1'b1, REG_EVENTS, 8'h00, q);
    chk(q, 8'h01);
    dev(1'b1, REG_EVENTS, 8'h00, q);
    chk(q, 8'h00);
    chk(general_out_pin, 7'h02);
    // pll input held high, so the selected clock stays high
    repeat (2) begin
      @(negedge clk);
      chk(recovered_clk_out, 1'b1);
    end
  endtask : t_clip
  // tracking, then disable and hold the estimate
  task automatic t_hpf();
    logic [7:0] q;
    logic [31:0] r;
    longint e;
    e = 0;
    dev(1'b0, REG_MISC, 8'h02, q);
    pulse(26'sd4096, 26'sd4096, 256);
    for (int i = 0; i < 256; i++) e = e + (((64'sd4096 <<< HPF_SHIFT) - e) >>> HPF_SHIFT);
    dev(1'b0, REG_MISC, 8'h01, q);
    pulse(26'sd4096, 26'sd4096, 4);
    apb(1'b1, H_IRQ_CLR, 32'h2, r); // stale flag would end a wait too early
    wait_rx();
    wait_rx();
    apb(1'b0, H_RX_BASE, 32'h0, r);
    chk(r, 32'(24'(64'sd4096 - (e >>> HPF_SHIFT))));
    apb(1'b1, H_IRQ_EN, 32'h0, r);
    repeat (4000) @(posedge clk);
    chk(irq, 1'b0);
    apb(1'b0, H_IRQ_ST, 32'h0, r);
    chk(r[IRQ_RX], 1'b1);
  endtask : t_hpf
  // main sequence
  initial begin
    repeat (20) @(posedge clk);
    srst <= 1'b0;
    t_regs();
    t_clip();
    t_hpf();
    finish_test();
  end
endmodule : tb_adc_output_path_hpf_overflow
`default_nettype wire
